// ===== core/p5om_top.sv
`timescale 1ns/1ps
// Contract
// - Source bits 4:2 select rx port 0-3 (000-011), status (100), reserved (101), tx 0/1 (11x).
// - With an rx port as source, codes 000-011 output its received remote pins 0-3.
// - With an rx port as source, code 100 outputs its lock and 101 its pass indication.
// - With an rx port as source, code 110 outputs its frame valid and 111 its line valid.
// - With device status as source, code 000 outputs the fixed level bit.
// - With device status as source, code 001 outputs the OR of lock over enabled rx ports.
// - With device status as source, code 010 outputs the AND of pass over enabled rx ports.
// - With device status as source, code 011 outputs frame sync and codes 100-111 are reserved.
// - With a tx port as source, 000 gives the AND and 001 the OR of pass over its mapped ports.
// - With a tx port as source, 010 is high during a sent frame and 011 during a sent line.
// - With a tx port as source, 100 shows that multi-port data is synchronized.
// - With a tx port as source, 101 outputs its interrupt and 110 and 111 are reserved.
// - Bit 1 holds the level driven when the pin outputs the register-controlled value.
// - Bit 0 enables the pin driver; all fields reset to zero, so the pin starts disabled.
module p5om_top
  import p5om_pkg::*;
#(
  parameter int NUM_RX = P5OM_NUM_RX,
  parameter int NUM_TX = P5OM_NUM_TX,
  parameter int NUM_RPIN = P5OM_NUM_RPIN
) (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [P5OM_AW-1:0] PADDR_I,
  input wire logic [P5OM_DW-1:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [P5OM_DW-1:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [NUM_RX*NUM_RPIN-1:0] RX_REMOTE_PIN_I,
  input wire logic [NUM_RX-1:0] RX_LOCK_I,
  input wire logic [NUM_RX-1:0] RX_PASS_I,
  input wire logic [NUM_RX-1:0] RX_FRAME_VALID_I,
  input wire logic [NUM_RX-1:0] RX_LINE_VALID_I,
  input wire logic FRAME_SYNC_PULSE_I,
  input wire logic [NUM_TX-1:0] TX_FRAME_VALID_I,
  input wire logic [NUM_TX-1:0] TX_LINE_VALID_I,
  input wire logic [NUM_TX-1:0] TX_SYNCED_I,
  input wire logic [NUM_TX-1:0] TX_IRQ_I,
  output logic PIN5_O,
  output logic PIN5_OE_O
);
  // ==========================================
  // register state
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [NUM_RX-1:0] rxen_reg;
  logic [NUM_RX-1:0] rxen_next;
  logic [NUM_RX*NUM_TX-1:0] txmap_reg;
  logic [NUM_RX*NUM_TX-1:0] txmap_next;
  logic [P5OM_DW-1:0] rdata_reg;
  logic [P5OM_DW-1:0] rdata_next;
  logic slverr_reg;
  logic slverr_next;
  logic pin_reg;
  logic pin_next;
  logic oe_reg;
  logic oe_next;

  logic setup_ph;
  logic wr_acc;
  logic mapped;
  logic [2:0] src;
  logic [2:0] sel;
  logic level;

  logic [NUM_RPIN-1:0] pk_rpin;
  logic pk_lock;
  logic pk_pass;
  logic pk_fv;
  logic pk_lv;

  function automatic logic addr_hit(input logic [P5OM_AW-1:0] a);
    addr_hit = (a == P5OM_CTL_ADDR) || (a == P5OM_RXEN_ADDR) ||
               (a == P5OM_TXMAP_ADDR) || (a == P5OM_STAT_ADDR);
  endfunction

  assign src = ctl_reg[P5OM_SRC_HI:P5OM_SRC_LO];
  assign sel = ctl_reg[P5OM_SEL_HI:P5OM_SEL_LO];

  // ==========================================
  // source selection
  p5om_rx_pick #(
    .NUM_RX(NUM_RX),
    .NUM_RPIN(NUM_RPIN)
  ) u_pick (
    .idx_i(src[1:0]),
    .rpin_i(RX_REMOTE_PIN_I),
    .lock_i(RX_LOCK_I),
    .pass_i(RX_PASS_I),
    .fv_i(RX_FRAME_VALID_I),
    .lv_i(RX_LINE_VALID_I),
    .rpin_o(pk_rpin),
    .lock_o(pk_lock),
    .pass_o(pk_pass),
    .fv_o(pk_fv),
    .lv_o(pk_lv)
  );

  p5om_select #(
    .NUM_RX(NUM_RX),
    .NUM_TX(NUM_TX)
  ) u_sel (
    .src_i(src),
    .sel_i(sel),
    .fixed_i(ctl_reg[P5OM_VAL_BIT]),
    .rx_rpin_i(pk_rpin[3:0]),
    .rx_lock_i(pk_lock),
    .rx_pass_i(pk_pass),
    .rx_fv_i(pk_fv),
    .rx_lv_i(pk_lv),
    .all_lock_i(RX_LOCK_I),
    .all_pass_i(RX_PASS_I),
    .rx_en_i(rxen_reg),
    .frame_sync_i(FRAME_SYNC_PULSE_I),
    .tx_map_i(txmap_reg),
    .tx_fv_i(TX_FRAME_VALID_I),
    .tx_lv_i(TX_LINE_VALID_I),
    .tx_sync_i(TX_SYNCED_I),
    .tx_irq_i(TX_IRQ_I),
    .level_o(level)
  );

  // ==========================================
  // apb slave: read data and error are latched in the setup
  // cycle, so the access phase always completes in one cycle
  assign setup_ph = PSEL_I && !PENABLE_I;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0];
  assign mapped = addr_hit(PADDR_I);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = slverr_reg && PSEL_I && PENABLE_I;
  assign PRDATA_O = rdata_reg;

  always_comb begin
    ctl_next = ctl_reg;
    rxen_next = rxen_reg;
    txmap_next = txmap_reg;
    rdata_next = rdata_reg;
    slverr_next = slverr_reg;
    if (setup_ph) begin
      slverr_next = !mapped;
      rdata_next = '0;
      if (!PWRITE_I) begin
        case (PADDR_I)
          P5OM_CTL_ADDR: rdata_next[7:0] = ctl_reg;
          P5OM_RXEN_ADDR: rdata_next[NUM_RX-1:0] = rxen_reg;
          P5OM_TXMAP_ADDR: rdata_next[NUM_RX*NUM_TX-1:0] = txmap_reg;
          P5OM_STAT_ADDR: rdata_next[1:0] = {pin_reg, oe_reg};
          default: rdata_next = '0;
        endcase
      end
    end
    // only the lowest byte lane holds register bits
    if (wr_acc) begin
      case (PADDR_I)
        P5OM_CTL_ADDR: ctl_next = PWDATA_I[7:0];
        P5OM_RXEN_ADDR: rxen_next = PWDATA_I[NUM_RX-1:0];
        P5OM_TXMAP_ADDR: txmap_next = PWDATA_I[NUM_RX*NUM_TX-1:0];
        default: ctl_next = ctl_reg;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ctl_reg <= P5OM_CTL_RST;
      rxen_reg <= P5OM_RXEN_RST;
      txmap_reg <= P5OM_TXMAP_RST;
      rdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      rxen_reg <= rxen_next;
      txmap_reg <= txmap_next;
      rdata_reg <= rdata_next;
      slverr_reg <= slverr_next;
    end
  end

  // ==========================================
  // pin driver: one flop stage so the pad sees no decode glitches
  always_comb begin
    oe_next = ctl_reg[P5OM_EN_BIT];
    pin_next = ctl_reg[P5OM_EN_BIT] && level;
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pin_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
      oe_reg <= oe_next;
    end
  end

  assign PIN5_O = pin_reg;
  assign PIN5_OE_O = oe_reg;

  // ==========================================
  // checks
  logic en_c;
  logic rx_c;
  logic dev_c;
  logic tx_c;
  logic [NUM_RX-1:0] tx_ports_c;
  assign en_c = ctl_reg[P5OM_EN_BIT];
  assign tx_ports_c = txmap_reg[src[0]*NUM_RX +: NUM_RX];
  assign rx_c = (src[2] == 1'b0);
  assign dev_c = (src == P5OM_SRC_DEV);
  assign tx_c = (src[2:1] == 2'b11);

  rx_remote_pin_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && rx_c && !sel[2] |=>
      PIN5_O == $past(RX_REMOTE_PIN_I[{src[1:0], sel[1:0]}]))
  else $error("pin does not follow received remote pin");

  rx_lock_pass_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && rx_c && sel[2:1] == 2'b10 |=>
      PIN5_O == $past(sel[0] ? RX_PASS_I[src[1:0]] : RX_LOCK_I[src[1:0]]))
  else $error("pin does not follow rx lock or pass");

  rx_video_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && rx_c && sel[2:1] == 2'b11 |=> PIN5_O == $past(sel[0] ?
      RX_LINE_VALID_I[src[1:0]] : RX_FRAME_VALID_I[src[1:0]]))
  else $error("pin does not follow rx frame or line valid");

  dev_fixed_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && dev_c && sel == P5OM_DEV_FIXED ##1 $stable(ctl_reg) |->
      PIN5_O == ctl_reg[P5OM_VAL_BIT])
  else $error("pin does not hold the fixed level");

  dev_lock_or_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && dev_c && sel == P5OM_DEV_LOCK_OR |=>
      PIN5_O == $past(|(RX_LOCK_I & rxen_reg)))
  else $error("pin is not the or of enabled locks");

  dev_pass_and_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && dev_c && sel == P5OM_DEV_PASS_AND |=> PIN5_O ==
      $past(rxen_reg != '0 && (RX_PASS_I & rxen_reg) == rxen_reg))
  else $error("pin is not the and of enabled passes");

  dev_fsync_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && dev_c && sel == P5OM_DEV_FSYNC |=>
      PIN5_O == $past(FRAME_SYNC_PULSE_I))
  else $error("pin does not follow frame sync");

  tx_pass_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && tx_c && sel == P5OM_TX_PASS_OR |=> PIN5_O ==
      $past(|(RX_PASS_I & txmap_reg[src[0]*NUM_RX +: NUM_RX])))
  else $error("pin is not the or of mapped passes");

  tx_pass_and_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && tx_c && sel == P5OM_TX_PASS_AND |=> PIN5_O ==
      $past(tx_ports_c != '0 && (RX_PASS_I & tx_ports_c) == tx_ports_c))
  else $error("pin is not the and of mapped passes");

  tx_video_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && tx_c && sel[2:1] == 2'b01 |=> PIN5_O == $past(sel[0] ?
      TX_LINE_VALID_I[src[0]] : TX_FRAME_VALID_I[src[0]]))
  else $error("pin does not follow tx frame or line");

  tx_sync_irq_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    en_c && tx_c && sel[2:1] == 2'b10 |=> PIN5_O ==
      $past(sel[0] ? TX_IRQ_I[src[0]] : TX_SYNCED_I[src[0]]))
  else $error("pin does not follow tx sync or interrupt");

  reserved_low_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    src == P5OM_SRC_RSV || (dev_c && sel > P5OM_DEV_FSYNC) ||
      (tx_c && sel[2:1] == 2'b11) |=> !PIN5_O)
  else $error("reserved code does not drive low");

  drive_gate_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    1'b1 |=> PIN5_OE_O == $past(en_c) && (!PIN5_O || PIN5_OE_O))
  else $error("pin drive does not follow the enable bit");

  ctl_write_a: assert property (
    @(posedge CLK_I) disable iff (!RESET_N_I)
    wr_acc && PADDR_I == P5OM_CTL_ADDR |=>
      ctl_reg == $past(PWDATA_I[7:0]))
  else $error("control write not taken");
endmodule

// ===== shared/p5om_pkg.sv
package p5om_pkg;
  // ==========================================
  // sizes
  localparam int P5OM_NUM_RX = 4;
  localparam int P5OM_NUM_TX = 2;
  localparam int P5OM_NUM_RPIN = 4;
  localparam int P5OM_AW = 8;
  localparam int P5OM_DW = 32;
  // ==========================================
  // register indices; byte address is four times the index
  localparam int P5OM_CTL_IDX = 'h15;
  localparam int P5OM_RXEN_IDX = 'h20;
  localparam int P5OM_TXMAP_IDX = 'h21;
  localparam int P5OM_STAT_IDX = 'h22;
  localparam logic [7:0] P5OM_CTL_ADDR = 8'(P5OM_CTL_IDX * 4);
  localparam logic [7:0] P5OM_RXEN_ADDR = 8'(P5OM_RXEN_IDX * 4);
  localparam logic [7:0] P5OM_TXMAP_ADDR = 8'(P5OM_TXMAP_IDX * 4);
  localparam logic [7:0] P5OM_STAT_ADDR = 8'(P5OM_STAT_IDX * 4);
  // ==========================================
  // control register fields
  localparam int P5OM_SEL_HI = 7;
  localparam int P5OM_SEL_LO = 5;
  localparam int P5OM_SRC_HI = 4;
  localparam int P5OM_SRC_LO = 2;
  localparam int P5OM_VAL_BIT = 1;
  localparam int P5OM_EN_BIT = 0;
  localparam logic [7:0] P5OM_CTL_RST = 8'h00;
  localparam logic [3:0] P5OM_RXEN_RST = 4'h0;
  localparam logic [7:0] P5OM_TXMAP_RST = 8'h00;
  // ==========================================
  // source groups
  typedef enum logic [2:0] {
    P5OM_SRC_RX0 = 3'b000,
    P5OM_SRC_RX1 = 3'b001,
    P5OM_SRC_RX2 = 3'b010,
    P5OM_SRC_RX3 = 3'b011,
    P5OM_SRC_DEV = 3'b100,
    P5OM_SRC_RSV = 3'b101,
    P5OM_SRC_TX0 = 3'b110,
    P5OM_SRC_TX1 = 3'b111
  } p5om_src_e;
  // ==========================================
  // signal select codes
  localparam logic [2:0] P5OM_RX_LOCK = 3'h4;
  localparam logic [2:0] P5OM_RX_PASS = 3'h5;
  localparam logic [2:0] P5OM_RX_FV = 3'h6;
  localparam logic [2:0] P5OM_RX_LV = 3'h7;
  localparam logic [2:0] P5OM_DEV_FIXED = 3'h0;
  localparam logic [2:0] P5OM_DEV_LOCK_OR = 3'h1;
  localparam logic [2:0] P5OM_DEV_PASS_AND = 3'h2;
  localparam logic [2:0] P5OM_DEV_FSYNC = 3'h3;
  localparam logic [2:0] P5OM_TX_PASS_AND = 3'h0;
  localparam logic [2:0] P5OM_TX_PASS_OR = 3'h1;
  localparam logic [2:0] P5OM_TX_FV = 3'h2;
  localparam logic [2:0] P5OM_TX_LV = 3'h3;
  localparam logic [2:0] P5OM_TX_SYNC = 3'h4;
  localparam logic [2:0] P5OM_TX_IRQ = 3'h5;
endpackage

// ===== core/p5om_rx_pick.sv
`timescale 1ns/1ps
// ==========================================
// picks one receive port's signals by index
module p5om_rx_pick
  import p5om_pkg::*;
#(
  parameter int NUM_RX = 4,
  parameter int NUM_RPIN = 4
) (
  input wire logic [1:0] idx_i,
  input wire logic [NUM_RX*NUM_RPIN-1:0] rpin_i,
  input wire logic [NUM_RX-1:0] lock_i,
  input wire logic [NUM_RX-1:0] pass_i,
  input wire logic [NUM_RX-1:0] fv_i,
  input wire logic [NUM_RX-1:0] lv_i,
  output logic [NUM_RPIN-1:0] rpin_o,
  output logic lock_o,
  output logic pass_o,
  output logic fv_o,
  output logic lv_o
);
  always_comb begin
    rpin_o = rpin_i[idx_i*NUM_RPIN +: NUM_RPIN];
    lock_o = lock_i[idx_i];
    pass_o = pass_i[idx_i];
    fv_o = fv_i[idx_i];
    lv_o = lv_i[idx_i];
  end
endmodule

// ===== core/p5om_select.sv
`timescale 1ns/1ps
// ==========================================
// group and signal selection for the pin
module p5om_select
  import p5om_pkg::*;
#(
  parameter int NUM_RX = 4,
  parameter int NUM_TX = 2
) (
  input wire logic [2:0] src_i,
  input wire logic [2:0] sel_i,
  input wire logic fixed_i,
  input wire logic [3:0] rx_rpin_i,
  input wire logic rx_lock_i,
  input wire logic rx_pass_i,
  input wire logic rx_fv_i,
  input wire logic rx_lv_i,
  input wire logic [NUM_RX-1:0] all_lock_i,
  input wire logic [NUM_RX-1:0] all_pass_i,
  input wire logic [NUM_RX-1:0] rx_en_i,
  input wire logic frame_sync_i,
  input wire logic [NUM_RX*NUM_TX-1:0] tx_map_i,
  input wire logic [NUM_TX-1:0] tx_fv_i,
  input wire logic [NUM_TX-1:0] tx_lv_i,
  input wire logic [NUM_TX-1:0] tx_sync_i,
  input wire logic [NUM_TX-1:0] tx_irq_i,
  output logic level_o
);
  // an empty port set reads as low for both reductions, so an
  // unconfigured pin never claims pass or lock
  function automatic logic set_and(input logic [NUM_RX-1:0] v,
                                   input logic [NUM_RX-1:0] m);
    set_and = (m != '0) && ((v & m) == m);
  endfunction

  function automatic logic set_or(input logic [NUM_RX-1:0] v,
                                  input logic [NUM_RX-1:0] m);
    set_or = |(v & m);
  endfunction

  logic tx_idx;
  logic [NUM_RX-1:0] tx_sel_ports;

  always_comb begin
    tx_idx = src_i[0];
    tx_sel_ports = tx_map_i[tx_idx*NUM_RX +: NUM_RX];
    level_o = 1'b0;
    case (src_i)
      P5OM_SRC_RX0, P5OM_SRC_RX1, P5OM_SRC_RX2, P5OM_SRC_RX3: begin
        case (sel_i)
          3'h0, 3'h1, 3'h2, 3'h3: level_o = rx_rpin_i[sel_i[1:0]];
          P5OM_RX_LOCK: level_o = rx_lock_i;
          P5OM_RX_PASS: level_o = rx_pass_i;
          P5OM_RX_FV: level_o = rx_fv_i;
          P5OM_RX_LV: level_o = rx_lv_i;
          default: level_o = 1'b0;
        endcase
      end
      P5OM_SRC_DEV: begin
        case (sel_i)
          P5OM_DEV_FIXED: level_o = fixed_i;
          P5OM_DEV_LOCK_OR: level_o = set_or(all_lock_i, rx_en_i);
          P5OM_DEV_PASS_AND: level_o = set_and(all_pass_i, rx_en_i);
          P5OM_DEV_FSYNC: level_o = frame_sync_i;
          default: level_o = 1'b0;
        endcase
      end
      P5OM_SRC_TX0, P5OM_SRC_TX1: begin
        case (sel_i)
          P5OM_TX_PASS_AND: level_o = set_and(all_pass_i, tx_sel_ports);
          P5OM_TX_PASS_OR: level_o = set_or(all_pass_i, tx_sel_ports);
          P5OM_TX_FV: level_o = tx_fv_i[tx_idx];
          P5OM_TX_LV: level_o = tx_lv_i[tx_idx];
          P5OM_TX_SYNC: level_o = tx_sync_i[tx_idx];
          P5OM_TX_IRQ: level_o = tx_irq_i[tx_idx];
          default: level_o = 1'b0;
        endcase
      end
      default: level_o = 1'b0;
    endcase
  end
endmodule

// ===== test/p5om_pin_board.sv
`timescale 1ns/1ps
// ==========================================
// board side of pin 5: a pull-down holds the net low while the device
// leaves it undriven, so a released pin never shows a stale level
module p5om_pin_board (
  input wire logic pin_i,
  input wire logic oe_i,
  output logic level_o
);
  assign level_o = oe_i ? pin_i : 1'b0;
endmodule

// ===== test/p5om_top_tb.sv
`timescale 1ns/1ps
module p5om_top_tb;
  import p5om_pkg::*;
  typedef struct {
    logic [7:0] ctl;
    int idx;
    logic inv;
    logic [3:0] en;
    logic [7:0] map;
    logic exp;
  } p5om_row_s;
  // ==========================================
  // stimulus bits: rpin 15:0, lock 19:16, pass 23:20, fv 27:24, lv 31:28,
  // sync 32, tx fv 34:33, tx lv 36:35, tx synced 38:37, tx irq 40:39
  p5om_row_s rows [32] = '{
    '{8'h05, 4, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'h25, 5, 1'b1, 4'h0, 8'h00, 1'b0},
    '{8'h49, 10, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'h6d, 15, 1'b1, 4'h0, 8'h00, 1'b0},
    '{8'h81, 16, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'had, 23, 1'b0, 4'h0, 8'h00, 1'b1},
    '{8'hc9, 26, 1'b1, 4'h0, 8'h00, 1'b0}, '{8'he5, 29, 1'b0, 4'h0, 8'h00, 1'b1},
    '{8'h13, 63, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'h11, 63, 1'b1, 4'h0, 8'h00, 1'b0},
    '{8'h31, 18, 1'b0, 4'h4, 8'h00, 1'b1}, '{8'h31, 18, 1'b0, 4'hb, 8'h00, 1'b0},
    '{8'h51, 20, 1'b1, 4'h6, 8'h00, 1'b1}, '{8'h51, 20, 1'b1, 4'h7, 8'h00, 1'b0},
    '{8'h71, 32, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'h71, 32, 1'b1, 4'h0, 8'h00, 1'b0},
    '{8'h91, 63, 1'b1, 4'hf, 8'h00, 1'b0}, '{8'hf1, 63, 1'b1, 4'hf, 8'h00, 1'b0},
    '{8'h15, 63, 1'b1, 4'h0, 8'h00, 1'b0}, '{8'hf5, 63, 1'b1, 4'h0, 8'h00, 1'b0},
    '{8'h19, 21, 1'b1, 4'h0, 8'h03, 1'b0}, '{8'h19, 21, 1'b1, 4'h0, 8'h0c, 1'b1},
    '{8'h3d, 22, 1'b0, 4'h0, 8'h40, 1'b1}, '{8'h3d, 22, 1'b0, 4'h0, 8'h84, 1'b0},
    '{8'h59, 33, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'h5d, 33, 1'b0, 4'h0, 8'h00, 1'b0},
    '{8'h7d, 36, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'h99, 37, 1'b0, 4'h0, 8'h00, 1'b1},
    '{8'hbd, 40, 1'b0, 4'h0, 8'h00, 1'b1}, '{8'hd9, 63, 1'b1, 4'h0, 8'hff, 1'b0},
    '{8'hfd, 63, 1'b1, 4'h0, 8'hff, 1'b0}, '{8'h12, 63, 1'b1, 4'h0, 8'h00, 1'b0}
  };
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pin, pin_oe, level, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [40:0] stim;
  int errors, n_compared, cycles;
  p5om_top dut (
    .CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .RX_REMOTE_PIN_I(stim[15:0]), .RX_LOCK_I(stim[19:16]), .RX_PASS_I(stim[23:20]),
    .RX_FRAME_VALID_I(stim[27:24]), .RX_LINE_VALID_I(stim[31:28]),
    .FRAME_SYNC_PULSE_I(stim[32]), .TX_FRAME_VALID_I(stim[34:33]),
    .TX_LINE_VALID_I(stim[36:35]), .TX_SYNCED_I(stim[38:37]), .TX_IRQ_I(stim[40:39]),
    .PIN5_O(pin), .PIN5_OE_O(pin_oe)
  );
  p5om_pin_board board (.pin_i(pin), .oe_i(pin_oe), .level_o(level));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================
  // bus and check tasks
  // entered right after a rising edge; psel stays up so calls run back to back
  task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= we;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    penable <= 1'b0;
  endtask
  task automatic idle;
    psel <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch and ends the run through the report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb, stim} = '0;
    {errors, n_compared, cycles} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      apb(1'b1, P5OM_RXEN_ADDR, {28'h0, rows[i].en}, 4'hf, rd, err);
      apb(1'b1, P5OM_TXMAP_ADDR, {24'h0, rows[i].map}, 4'hf, rd, err);
      apb(1'b1, P5OM_CTL_ADDR, {24'h0, rows[i].ctl}, 4'hf, rd, err);
      stim <= rows[i].inv ? ~(41'h1 << rows[i].idx) : (41'h1 << rows[i].idx);
      idle();
      settle();
      check({31'h0, pin}, {31'h0, rows[i].exp});
      check({31'h0, pin_oe}, {31'h0, rows[i].ctl[0]});
      check({31'h0, level}, {31'h0, rows[i].exp});
      @(posedge clk);
    end
    apb(1'b1, P5OM_CTL_ADDR, 32'h13, 4'hf, rd, err);
    idle();
    settle();
    check({30'h0, pin, pin_oe}, 32'h3);
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check({30'h0, pin, pin_oe}, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, P5OM_CTL_ADDR, 32'h0, 4'hf, rd, err);
    check(rd, 32'h0);
    apb(1'b0, P5OM_RXEN_ADDR, 32'h0, 4'hf, rd, err);
    check(rd, 32'h0);
    apb(1'b0, P5OM_TXMAP_ADDR, 32'h0, 4'hf, rd, err);
    check(rd, 32'h0);
    // a write without its low strobe must leave the control word alone
    apb(1'b1, P5OM_CTL_ADDR, 32'h13, 4'h0, rd, err);
    apb(1'b0, P5OM_CTL_ADDR, 32'h0, 4'hf, rd, err);
    check(rd, 32'h0);
    apb(1'b1, 8'h00, 32'hff, 4'hf, rd, err);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h04, 32'h0, 4'hf, rd, err);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, P5OM_CTL_ADDR, 32'h13, 4'hf, rd, err);
    apb(1'b0, P5OM_CTL_ADDR, 32'h0, 4'hf, rd, err);
    check(rd, 32'h13);
    idle();
    settle();
    @(posedge clk);
    apb(1'b1, P5OM_STAT_ADDR, 32'h0, 4'hf, rd, err);
    check({31'h0, err}, 32'h0);
    apb(1'b0, P5OM_STAT_ADDR, 32'h0, 4'hf, rd, err);
    check(rd, 32'h3);
    idle();
    results();
  end
endmodule
